// ---- logic/pdmc_power_down.sv ----
`timescale 1ns/10ps
// Overview of operation
// - SLEEP stops the core only and ends on reset or interrupt after at least 1.5 clocks.
// - I/O STOP halts on-chip I/O only and is left by clearing the control bit.
// - SYSTEM STOP stops core and I/O and ends on reset or interrupt after at least 1.5 clocks.
// - IDLE also stops the clock output and ends on reset, interrupt or bus request after 9.5 clocks.
// - STANDBY also stops the oscillator and wakes on reset, interrupt or bus request.
// - Quick recovery shortens the STANDBY wake wait to 2^6 plus 1.5 clocks instead of 2^17.
// - Bits D6 and D3 of cpu_control pick STANDBY (1,0) or IDLE.
// - An 18-bit counter counts 2^17 after a wake request before the source is acknowledged.
// - If the waking source drops during the count the device falls back into STANDBY.
// - Reset held through STANDBY restarts the device with normal reset timing from address 0.
// - Under reset the oscillator and system clock output run again at once.
module pdmc_power_down
  import pdmc_pkg::*;
#(
  parameter int STANDBY_STAB_CYC = PDMC_NORMAL_CYC
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic sleep_exec,
  input wire logic irq,
  input wire logic external_bus_request,
  output logic cpu_stop,
  output logic io_stop,
  output logic osc_stop,
  output logic system_clock_output_en,
  output logic wake_ack
);
  // ==========================================================================
  // Registers
  logic [7:0] cpu_control_q;
  logic [7:0] cpu_control_d;
  logic [7:0] io_control_q;
  logic [7:0] io_control_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    cpu_control_d = cpu_control_q;
    io_control_d = io_control_q;
    rdata_d = rdata_q;
    if (io_wr && io_addr == PDMC_CPU_CONTROL_ADDR) begin
      cpu_control_d = io_wdata;
    end
    if (io_wr && io_addr == PDMC_IO_CONTROL_ADDR) begin
      io_control_d = io_wdata;
    end
    if (io_rd) begin
      case (io_addr)
        PDMC_CPU_CONTROL_ADDR: rdata_d = cpu_control_q;
        PDMC_IO_CONTROL_ADDR: rdata_d = io_control_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_control_q <= PDMC_CPU_CONTROL_RST;
      io_control_q <= PDMC_IO_CONTROL_RST;
      rdata_q <= 8'h00;
    end else begin
      cpu_control_q <= cpu_control_d;
      io_control_q <= io_control_d;
      rdata_q <= rdata_d;
    end
  end

  assign io_rdata = rdata_q;

  // ==========================================================================
  // Mode decode
  logic io_stop_bit;
  logic sel_standby;
  logic sel_idle;
  logic any_wake;

  assign io_stop_bit = io_control_q[PDMC_IO_STOP_BIT];
  assign sel_standby = cpu_control_q[PDMC_MODE_HI_BIT] && !cpu_control_q[PDMC_MODE_LO_BIT];
  assign sel_idle = !cpu_control_q[PDMC_MODE_HI_BIT] && cpu_control_q[PDMC_MODE_LO_BIT];
  assign any_wake = irq || external_bus_request;

  // ==========================================================================
  // Sequencer
  pdmc_state_t state_q;
  pdmc_state_t state_d;
  logic sys_stop_q;
  logic sys_stop_d;
  logic ack_q;
  logic ack_d;
  logic cnt_load;
  logic [PDMC_CNT_W-1:0] cnt_val;
  logic cnt_dec;
  logic cnt_done;

  always_comb begin
    state_d = state_q;
    sys_stop_d = sys_stop_q;
    ack_d = 1'b0;
    cnt_load = 1'b0;
    cnt_val = PDMC_RECOV_CYC;
    cnt_dec = 1'b0;
    case (state_q)
      PDMC_RUN: begin
        if (sleep_exec) begin
          // Remembered for every stop so recovery keeps the I/O halted
          sys_stop_d = io_stop_bit;
          if (io_stop_bit && sel_standby) begin
            state_d = PDMC_STANDBY;
          end else if (io_stop_bit && sel_idle) begin
            state_d = PDMC_IDLE;
          end else begin
            state_d = PDMC_HALTED;
          end
        end
      end
      PDMC_HALTED: begin
        if (irq) begin
          state_d = PDMC_RECOV;
          cnt_load = 1'b1;
          cnt_val = PDMC_RECOV_CYC;
        end
      end
      PDMC_IDLE: begin
        if (any_wake) begin
          state_d = PDMC_RECOV;
          cnt_load = 1'b1;
          cnt_val = PDMC_IDLE_CYC;
        end
      end
      PDMC_STANDBY: begin
        if (any_wake) begin
          state_d = PDMC_STAB;
          cnt_load = 1'b1;
          if (cpu_control_q[PDMC_QUICK_BIT]) begin
            cnt_val = PDMC_QUICK_CYC;
          end else begin
            cnt_val = PDMC_CNT_W'(STANDBY_STAB_CYC);
          end
        end
      end
      PDMC_STAB: begin
        cnt_dec = 1'b1;
        if (!any_wake) begin
          state_d = PDMC_STANDBY;
        end else if (cnt_done) begin
          state_d = PDMC_RECOV;
          cnt_load = 1'b1;
          cnt_val = PDMC_RECOV_CYC;
        end
      end
      PDMC_RECOV: begin
        cnt_dec = 1'b1;
        if (cnt_done) begin
          state_d = PDMC_RUN;
          sys_stop_d = 1'b0;
          ack_d = 1'b1;
        end
      end
      default: begin
        state_d = PDMC_RUN;
      end
    endcase
  end

  // Reset returns every stage to running clocks at once
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= PDMC_RUN;
      sys_stop_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sys_stop_q <= sys_stop_d;
      ack_q <= ack_d;
    end
  end

  pdmc_down_counter u_stab_cnt (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(cnt_load),
    .load_val(cnt_val),
    .dec(cnt_dec),
    .done(cnt_done)
  );

  // ==========================================================================
  // Stop controls
  logic core_stop;
  logic unit_stop;
  logic clk_stop;
  logic osc_off;

  // Recovery keeps the I/O of the mode being left halted until the core runs
  always_comb begin
    core_stop = 1'b1;
    unit_stop = sys_stop_q;
    clk_stop = 1'b0;
    osc_off = 1'b0;
    case (state_q)
      PDMC_RUN: begin
        core_stop = 1'b0;
        unit_stop = io_stop_bit;
      end
      PDMC_HALTED: begin
        unit_stop = sys_stop_q;
      end
      PDMC_IDLE: begin
        unit_stop = 1'b1;
        clk_stop = 1'b1;
      end
      PDMC_STANDBY: begin
        unit_stop = 1'b1;
        clk_stop = 1'b1;
        osc_off = 1'b1;
      end
      PDMC_STAB: begin
        unit_stop = 1'b1;
        clk_stop = 1'b1;
      end
      default: begin
        core_stop = 1'b1;
      end
    endcase
  end

  assign cpu_stop = core_stop;
  assign io_stop = unit_stop;
  assign osc_stop = osc_off;
  assign system_clock_output_en = !clk_stop;
  assign wake_ack = ack_q;
endmodule // pdmc_power_down

// ---- logic/pdmc_pkg.sv ----
package pdmc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] PDMC_CPU_CONTROL_ADDR = 8'h1f;
  localparam logic [7:0] PDMC_IO_CONTROL_ADDR = 8'h3f;
  localparam logic [7:0] PDMC_CPU_CONTROL_RST = 8'h00;
  localparam logic [7:0] PDMC_IO_CONTROL_RST = 8'h00;
  // ==========================================================================
  // Field positions
  localparam int PDMC_MODE_HI_BIT = 6;
  localparam int PDMC_MODE_LO_BIT = 3;
  localparam int PDMC_QUICK_BIT = 7;
  localparam int PDMC_IO_STOP_BIT = 5;
  // ==========================================================================
  // Timing, in half clocks, and derived whole cycles
  localparam int PDMC_CNT_W = 18;
  localparam int PDMC_RECOV_HALF_CLKS = 3;
  localparam int PDMC_IDLE_HALF_CLKS = 19;
  localparam int PDMC_QUICK_EXP = 6;
  localparam int PDMC_NORMAL_EXP = 17;
  localparam logic [PDMC_CNT_W-1:0] PDMC_RECOV_CYC = PDMC_CNT_W'((PDMC_RECOV_HALF_CLKS + 1) / 2);
  localparam logic [PDMC_CNT_W-1:0] PDMC_IDLE_CYC = PDMC_CNT_W'((PDMC_IDLE_HALF_CLKS + 1) / 2);
  localparam logic [PDMC_CNT_W-1:0] PDMC_QUICK_CYC = PDMC_CNT_W'(1 << PDMC_QUICK_EXP);
  localparam int PDMC_NORMAL_CYC = 1 << PDMC_NORMAL_EXP;
  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    PDMC_RUN, PDMC_HALTED, PDMC_IDLE, PDMC_STANDBY, PDMC_STAB, PDMC_RECOV
  } pdmc_state_t;
endpackage

// ---- logic/pdmc_down_counter.sv ----
`timescale 1ns/10ps
module pdmc_down_counter
  import pdmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [PDMC_CNT_W-1:0] load_val,
  input wire logic dec,
  output logic done
);
  logic [PDMC_CNT_W-1:0] cnt_q;
  logic [PDMC_CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (dec && cnt_q != '0) begin
      cnt_d = cnt_q - PDMC_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Load is not looked at here: the sequencer loads on done, which would close a loop
  assign done = (cnt_q == PDMC_CNT_W'(1)) && dec;
endmodule // pdmc_down_counter

// ---- sim/pdmc_power_down_props.sv ----
`timescale 1ns/10ps
module pdmc_power_down_props
  import pdmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic sleep_exec,
  input wire logic irq,
  input wire logic external_bus_request,
  input wire logic cpu_stop,
  input wire logic io_stop,
  input wire logic osc_stop,
  input wire logic system_clock_output_en,
  input wire logic wake_ack
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence halt_wake_s;
    $rose(irq) && cpu_stop && system_clock_output_en;
  endsequence
  sequence idle_wake_s;
    $rose(external_bus_request) && !system_clock_output_en && !osc_stop;
  endsequence
  // Only a source held past the first cycles is owed an acknowledge
  sequence stab_wake_s;
    ($rose(irq) || $rose(external_bus_request)) && osc_stop ##1 (irq || external_bus_request) [*8];
  endsequence
  sleep_stop_a: assert property (sleep_exec && !cpu_stop |=> cpu_stop)
    else $error("core not stopped after sleep");
  wake_run_a: assert property ($fell(cpu_stop) |-> wake_ack)
    else $error("core restarted without acknowledge");
  ack_pulse_a: assert property (wake_ack |=> !wake_ack && !cpu_stop)
    else $error("acknowledge not a single pulse");
  standby_stops_a: assert property (osc_stop |-> cpu_stop && io_stop && !system_clock_output_en)
    else $error("standby stop set incomplete");
  halt_wake_a: assert property (halt_wake_s |-> !wake_ack ##3 wake_ack)
    else $error("halted wake time wrong");
  idle_wake_a: assert property (idle_wake_s |-> ##11 wake_ack)
    else $error("idle wake time wrong");
  stab_wake_a: assert property (stab_wake_s |-> ##[10:62] wake_ack)
    else $error("standby wake time wrong");
  io_stop_a: assert property (io_wr && io_addr == PDMC_IO_CONTROL_ADDR && !cpu_stop
    |=> io_stop == $past(io_wdata[PDMC_IO_STOP_BIT])) else $error("io stop not following bit");
endmodule // pdmc_power_down_props

bind pdmc_power_down pdmc_power_down_props u_props (.sys_clk(sys_clk), .nrst(nrst),
  .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata), .sleep_exec(sleep_exec), .irq(irq),
  .external_bus_request(external_bus_request), .cpu_stop(cpu_stop), .io_stop(io_stop),
  .osc_stop(osc_stop), .system_clock_output_en(system_clock_output_en), .wake_ack(wake_ack));

// ---- sim/pdmc_wake_src.sv ----
`timescale 1ns/10ps
module pdmc_wake_src (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic go_irq,
  input wire logic go_bus,
  input wire logic drop,
  input wire logic wake_ack,
  output logic irq,
  output logic external_bus_request
);
  // A request is held until acknowledged, or withdrawn on command
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
      external_bus_request <= 1'b0;
    end else if (wake_ack || drop) begin
      irq <= 1'b0;
      external_bus_request <= 1'b0;
    end else begin
      irq <= irq | go_irq;
      external_bus_request <= external_bus_request | go_bus;
    end
  end
endmodule // pdmc_wake_src

// ---- sim/test_power_down_mode_control.sv ----
`timescale 1ns/10ps
module test_power_down_mode_control;
  import pdmc_pkg::*;
  localparam int STAB = 20;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic sleep_exec = 1'b0;
  logic go_irq = 1'b0;
  logic go_bus = 1'b0;
  logic drop = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata, a, d;
  logic irq, external_bus_request, cpu_stop, io_stop, osc_stop, system_clock_output_en, wake_ack;
  logic [7:0] cc [4] = '{8'h00, 8'h00, 8'h08, 8'h40};
  logic [7:0] ic [4] = '{8'h00, 8'h20, 8'h20, 8'h20};
  logic [3:0] st [4] = '{4'b1001, 4'b1101, 4'b1100, 4'b1110};
  int num_errors = 0;
  int tests_run = 0;
  int n, e;
  pdmc_power_down #(.STANDBY_STAB_CYC(STAB)) uut (.sys_clk(sys_clk), .nrst(nrst),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .sleep_exec(sleep_exec), .irq(irq), .external_bus_request(external_bus_request),
    .cpu_stop(cpu_stop), .io_stop(io_stop), .osc_stop(osc_stop),
    .system_clock_output_en(system_clock_output_en), .wake_ack(wake_ack));
  pdmc_wake_src src (.sys_clk(sys_clk), .nrst(nrst), .go_irq(go_irq), .go_bus(go_bus),
    .drop(drop), .wake_ack(wake_ack), .irq(irq), .external_bus_request(external_bus_request));
  initial forever #2.5 sys_clk = ~sys_clk;
  task test_done;
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [7:0] ex, got);
    tests_run++;
    if (got !== ex) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, ex, got);
    end
  endtask
  task acc(input logic w, input logic [7:0] ad, dt);
    @(negedge sys_clk);
    io_wr = w;
    io_rd = !w;
    io_addr = ad;
    io_wdata = dt;
    @(negedge sys_clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask
  task rd(input logic [7:0] ad, ex);
    acc(1'b0, ad, 8'h00);
    chk("io_rdata", ex, io_rdata);
  endtask
  task stops(input logic [3:0] ex);
    chk("stops", {4'h0, ex}, {4'h0, cpu_stop, io_stop, osc_stop, system_clock_output_en});
  endtask
  // Source flop and sampling edge, then the counts loaded on wake
  function automatic int exp_wait(input int m, input logic q);
    int c;
    c = m == 2 ? int'(PDMC_IDLE_CYC) : int'(PDMC_RECOV_CYC);
    if (m == 3) c += q ? int'(PDMC_QUICK_CYC) : STAB;
    return c + 2;
  endfunction
  task automatic sleep_in(input int m, input logic q);
    acc(1'b1, PDMC_CPU_CONTROL_ADDR, cc[m] | {q, 7'h00});
    acc(1'b1, PDMC_IO_CONTROL_ADDR, ic[m]);
    @(negedge sys_clk);
    sleep_exec = 1'b1;
    @(negedge sys_clk);
    sleep_exec = 1'b0;
    stops(st[m]);
  endtask
  task automatic run_mode(input int m, input logic q, b, ab);
    sleep_in(m, q);
    if (ab) begin
      go_bus = 1'b1;
      repeat (5) @(negedge sys_clk);
      go_bus = 1'b0;
      drop = 1'b1;
      @(negedge sys_clk);
      drop = 1'b0;
      repeat (80) @(negedge sys_clk);
      stops(st[m]);
    end
    go_bus = b;
    go_irq = !b;
    n = 0;
    while (wake_ack !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    go_irq = 1'b0;
    go_bus = 1'b0;
    if (n == 200) begin
      num_errors++;
      test_done;
    end
    e = exp_wait(m, q);
    chk("wake_time", 8'(e), 8'(n));
    @(negedge sys_clk);
    stops({1'b0, ic[m][5], 2'b01});
    acc(1'b1, PDMC_IO_CONTROL_ADDR, 8'h00);
  endtask
  initial begin
    n = $urandom(21);
    repeat (16) @(negedge sys_clk);
    nrst = 1'b1;
    rd(PDMC_CPU_CONTROL_ADDR, PDMC_CPU_CONTROL_RST);
    rd(PDMC_IO_CONTROL_ADDR, PDMC_IO_CONTROL_RST);
    repeat (20) begin
      d = 8'($urandom);
      a = 8'($urandom);
      acc(1'b1, PDMC_IO_CONTROL_ADDR, d);
      chk("io_stop", {7'h00, d[5]}, {7'h00, io_stop});
      acc(1'b1, PDMC_CPU_CONTROL_ADDR, ~d);
      if (a != PDMC_CPU_CONTROL_ADDR && a != PDMC_IO_CONTROL_ADDR) acc(1'b1, a, d);
      rd(PDMC_CPU_CONTROL_ADDR, ~d);
      rd(PDMC_IO_CONTROL_ADDR, d);
      if (a != PDMC_CPU_CONTROL_ADDR && a != PDMC_IO_CONTROL_ADDR) rd(a, 8'h00);
    end
    acc(1'b1, PDMC_IO_CONTROL_ADDR, 8'h00);
    run_mode(0, 1'b0, 1'b0, 1'b0);
    run_mode(1, 1'b0, 1'b0, 1'b0);
    run_mode(2, 1'b0, 1'b1, 1'b0);
    run_mode(3, 1'b0, 1'b1, 1'b1);
    run_mode(3, 1'b1, 1'b0, 1'b0);
    // Reset taken in STANDBY brings the clocks back while it is still held
    sleep_in(3, 1'b0);
    nrst = 1'b0;
    @(negedge sys_clk);
    stops(4'b0001);
    repeat (15) @(negedge sys_clk);
    nrst = 1'b1;
    rd(PDMC_CPU_CONTROL_ADDR, PDMC_CPU_CONTROL_RST);
    rd(PDMC_IO_CONTROL_ADDR, PDMC_IO_CONTROL_RST);
    run_mode(0, 1'b0, 1'b0, 1'b0);
    test_done;
  end
endmodule // test_power_down_mode_control
